// ### design/agc_pkg.sv
// Package for address generation and canonical checking
package agc_pkg;
   // Operating modes
   typedef enum logic [2:0] {
      AGC_MODE_REAL,
      AGC_MODE_PROT,
      AGC_MODE_COMPAT,
      AGC_MODE_LONG64,
      AGC_MODE_MGMT
   } agc_mode_type;

   // Address sizes
   typedef enum logic [1:0] {
      AGC_ASZ_16,
      AGC_ASZ_32,
      AGC_ASZ_64
   } agc_asz_type;

   // Segments
   typedef enum logic [2:0] {
      AGC_SEG_CODE,
      AGC_SEG_DATA,
      AGC_SEG_EXTRA,
      AGC_SEG_STACK,
      AGC_SEG_THREAD_ONE,
      AGC_SEG_THREAD_TWO
   } agc_seg_type;

   // Instruction pointer update sizes
   typedef enum logic [1:0] {
      AGC_IPW_NONE,
      AGC_IPW_16,
      AGC_IPW_32,
      AGC_IPW_64
   } agc_ipw_type;

   localparam int AGC_ADDR_W = 64;
   localparam int AGC_DISP_W = 32;
   localparam int AGC_IMPL_MSB = 47;
   localparam logic [63:0] AGC_REAL_LIMIT = 64'h0000_0000_000F_FFFF;
   localparam logic [63:0] AGC_LIMIT_16 = 64'h0000_0000_0000_FFFF;
   localparam logic [63:0] AGC_LIMIT_32 = 64'h0000_0000_FFFF_FFFF;
   localparam logic [63:0] AGC_IP_RESET = 64'h0000_0000_0000_0000;

   // Request from decode
   typedef struct packed {
      logic valid;
      agc_mode_type mode;
      logic seg_default_32;
      logic asz_override;
      agc_seg_type seg;
      logic seg_override;
      logic base_valid;
      logic base_is_stack_ptr;
      logic base_is_frame_ptr;
      logic implied_stack;
      logic [63:0] base_val;
      logic index_valid;
      logic [63:0] index_val;
      logic [1:0] scale;
      logic wide_disp;
      logic [63:0] disp;
      logic [15:0] selector;
   } agc_req_type;

   // Result to the load/store pipeline
   typedef struct packed {
      logic valid;
      logic [63:0] eff_addr;
      logic [63:0] lin_addr;
      logic [15:0] selector;
      logic [63:0] offset;
      logic mgmt_space;
      logic general_protection_fault;
      logic stack_fault;
   } agc_rsp_type;
endpackage

// ### design/agc_address_gen.sv
// Effective and linear address generation with canonical checking
`timescale 1ns/1ps

// How it works
// RULE1: 64-bit mode uses full 64-bit base, index
// RULE2: Displacements sign-extended from 32 bits in 64-bit
// RULE3: Register-move form takes full 64-bit displacement
// RULE4: Code, data, extra, stack bases zero in 64-bit
// RULE5: Thread segments: truncate sum, then add full base
// RULE6: Extended long mode truncates then zero-extends
// RULE7: Pointer updates: 16 keeps top, 32 zero-extends
// RULE8: Canonical means high bits all equal
// RULE9: Bits 63 to 48 must equal bit 47
// RULE10: Non-stack canonical violation raises protection fault
// RULE11: Stack references raise stack fault instead
// RULE12: Thread override on stack base gives protection fault
// RULE13: Legacy segment overrides ignored in 64-bit mode
// RULE14: Real mode defaults to 16-bit addressing
// RULE15: Real mode linear address capped at 000FFFFF
// RULE16: Protected mode caps at FFFF or 2^32-1
// RULE17: Protected default size from code descriptor
// RULE18: Logical address is selector plus offset
// RULE19: 64-bit mode is flat, no segmentation except thread segment bases
// RULE20: Management state uses separate real-like space
// RULE21: Check final linear address, fault same cycle
module agc_address_gen (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Decode request
   input wire agc_pkg::agc_req_type i_req,
   // Segment bases
   input wire logic [63:0] i_code_seg_base,
   input wire logic [63:0] i_data_seg_base,
   input wire logic [63:0] i_extra_seg_base,
   input wire logic [63:0] i_stack_seg_base,
   input wire logic [63:0] i_thread_seg_one_base,
   input wire logic [63:0] i_thread_seg_two_base,
   // Instruction pointer update
   input wire agc_pkg::agc_ipw_type i_ip_wr_size,
   input wire logic [63:0] i_ip_wr_val,
   // Results
   output agc_pkg::agc_rsp_type o_rsp,
   output logic [63:0] o_wide_instr_ptr
);

   agc_pkg::agc_rsp_type rsp_ff;
   agc_pkg::agc_rsp_type nxt_rsp;
   logic [63:0] wide_instr_ptr_ff;
   logic [63:0] nxt_wide_instr_ptr;

   logic is_long64;
   logic is_ext_long;
   agc_pkg::agc_asz_type asz;
   agc_pkg::agc_seg_type seg_eff;
   logic [63:0] disp_ext;
   logic [63:0] index_scaled;
   logic [63:0] ea_sum;
   logic [63:0] ea_trunc;
   logic [63:0] seg_base;
   logic [63:0] lin_raw;
   logic [63:0] lin_final;
   logic canon_ok;
   logic stack_ref;

   assign is_long64 = (i_req.mode == agc_pkg::AGC_MODE_LONG64);
   assign is_ext_long = is_long64 || (i_req.mode == agc_pkg::AGC_MODE_COMPAT);

   // Effective address size
   always_comb begin
      unique case (i_req.mode)
         agc_pkg::AGC_MODE_LONG64: begin
            asz = i_req.asz_override ? agc_pkg::AGC_ASZ_32 : agc_pkg::AGC_ASZ_64; // RULE1
         end
         agc_pkg::AGC_MODE_PROT, agc_pkg::AGC_MODE_COMPAT: begin
            // Descriptor default flipped by prefix
            asz = (i_req.seg_default_32 ^ i_req.asz_override) ?
               agc_pkg::AGC_ASZ_32 : agc_pkg::AGC_ASZ_16; // RULE17
         end
         default: begin
            // Real and management modes
            asz = i_req.asz_override ? agc_pkg::AGC_ASZ_32 : agc_pkg::AGC_ASZ_16; // RULE14 RULE20
         end
      endcase
   end

   // Displacement extension
   always_comb begin
      if (is_long64 && i_req.wide_disp) begin
         disp_ext = i_req.disp; // RULE3
      end else begin
         disp_ext = {{32{i_req.disp[31]}}, i_req.disp[31:0]}; // RULE2
      end
   end

   // Effective address sum
   always_comb begin
      index_scaled = i_req.index_valid ? (i_req.index_val << i_req.scale) : 64'h0;
      ea_sum = (i_req.base_valid ? i_req.base_val : 64'h0) + index_scaled + disp_ext; // RULE1
   end

   // Truncate to address size, zero-extend
   always_comb begin
      unique case (asz)
         agc_pkg::AGC_ASZ_16: ea_trunc = {48'h0, ea_sum[15:0]}; // RULE6 RULE18
         agc_pkg::AGC_ASZ_32: ea_trunc = {32'h0, ea_sum[31:0]}; // RULE6 RULE18
         agc_pkg::AGC_ASZ_64: ea_trunc = ea_sum;
         default: ea_trunc = ea_sum;
      endcase
   end

   // Segment selection; legacy overrides dropped in 64-bit
   always_comb begin
      seg_eff = i_req.seg;
      if (is_long64 && i_req.seg_override &&
          (i_req.seg != agc_pkg::AGC_SEG_THREAD_ONE) &&
          (i_req.seg != agc_pkg::AGC_SEG_THREAD_TWO)) begin
         seg_eff = agc_pkg::AGC_SEG_DATA; // RULE13
         if (i_req.implied_stack || i_req.base_is_stack_ptr || i_req.base_is_frame_ptr) begin
            seg_eff = agc_pkg::AGC_SEG_STACK;
         end
      end
   end

   // Segment base
   always_comb begin
      unique case (seg_eff)
         agc_pkg::AGC_SEG_CODE: seg_base = i_code_seg_base;
         agc_pkg::AGC_SEG_DATA: seg_base = i_data_seg_base;
         agc_pkg::AGC_SEG_EXTRA: seg_base = i_extra_seg_base;
         agc_pkg::AGC_SEG_STACK: seg_base = i_stack_seg_base;
         agc_pkg::AGC_SEG_THREAD_ONE: seg_base = i_thread_seg_one_base;
         agc_pkg::AGC_SEG_THREAD_TWO: seg_base = i_thread_seg_two_base;
         default: seg_base = 64'h0;
      endcase
      if (is_long64 && (seg_eff != agc_pkg::AGC_SEG_THREAD_ONE) &&
          (seg_eff != agc_pkg::AGC_SEG_THREAD_TWO)) begin
         seg_base = 64'h0; // RULE4 RULE19
      end
   end

   // Linear address with mode limits
   always_comb begin
      if (is_long64) begin
         lin_raw = ea_trunc + seg_base; // RULE5
      end else begin
         lin_raw = {32'h0, ea_trunc[31:0] + seg_base[31:0]};
      end
      lin_final = lin_raw;
      unique case (i_req.mode)
         agc_pkg::AGC_MODE_REAL, agc_pkg::AGC_MODE_MGMT: begin
            lin_final = lin_raw & agc_pkg::AGC_REAL_LIMIT; // RULE15 RULE20
         end
         agc_pkg::AGC_MODE_PROT, agc_pkg::AGC_MODE_COMPAT: begin
            lin_final = lin_raw & agc_pkg::AGC_LIMIT_32; // RULE16
         end
         agc_pkg::AGC_MODE_LONG64: lin_final = lin_raw;
         default: lin_final = lin_raw;
      endcase
   end

   // Canonical check on final linear address
   always_comb begin
      canon_ok = (lin_final[63:agc_pkg::AGC_IMPL_MSB] == '0) ||
                 (lin_final[63:agc_pkg::AGC_IMPL_MSB] == '1); // RULE8 RULE9 RULE21
      stack_ref = i_req.implied_stack ||
                  (seg_eff == agc_pkg::AGC_SEG_STACK &&
                   (i_req.base_is_stack_ptr || i_req.base_is_frame_ptr)); // RULE11 RULE12
   end

   // Result composition
   always_comb begin
      nxt_rsp = '0;
      nxt_rsp.valid = i_req.valid;
      nxt_rsp.eff_addr = ea_trunc;
      nxt_rsp.lin_addr = lin_final;
      nxt_rsp.selector = i_req.selector; // RULE18
      nxt_rsp.offset = (asz == agc_pkg::AGC_ASZ_16) ?
         (ea_trunc & agc_pkg::AGC_LIMIT_16) : ea_trunc; // RULE16
      nxt_rsp.mgmt_space = (i_req.mode == agc_pkg::AGC_MODE_MGMT); // RULE20
      if (i_req.valid && is_long64 && !canon_ok) begin
         nxt_rsp.stack_fault = stack_ref; // RULE11
         nxt_rsp.general_protection_fault = !stack_ref; // RULE10 RULE12 RULE13
      end
      if (!is_ext_long) begin
         nxt_rsp.eff_addr = ea_trunc;
      end
   end

   // Instruction pointer update
   always_comb begin
      nxt_wide_instr_ptr = wide_instr_ptr_ff;
      unique case (i_ip_wr_size)
         agc_pkg::AGC_IPW_NONE: nxt_wide_instr_ptr = wide_instr_ptr_ff;
         agc_pkg::AGC_IPW_16: begin
            nxt_wide_instr_ptr = {wide_instr_ptr_ff[63:16], i_ip_wr_val[15:0]}; // RULE7
         end
         agc_pkg::AGC_IPW_32: nxt_wide_instr_ptr = {32'h0, i_ip_wr_val[31:0]}; // RULE7
         agc_pkg::AGC_IPW_64: nxt_wide_instr_ptr = i_ip_wr_val; // RULE7
      endcase
   end

   // Result register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff <= nxt_rsp;
      end
   end

   // Instruction pointer register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wide_instr_ptr_ff <= agc_pkg::AGC_IP_RESET;
      end else begin
         wide_instr_ptr_ff <= nxt_wide_instr_ptr;
      end
   end

   assign o_rsp = rsp_ff;
   assign o_wide_instr_ptr = wide_instr_ptr_ff;

endmodule

// ### verif/agc_address_gen_props.sv
// Checker for address generation and canonical faults
`timescale 1ns/1ps
module agc_address_gen_props (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Observed ports
   input wire agc_pkg::agc_req_type i_req,
   input wire agc_pkg::agc_ipw_type i_ip_wr_size,
   input wire logic [63:0] i_ip_wr_val,
   input wire agc_pkg::agc_rsp_type o_rsp,
   input wire logic [63:0] o_wide_instr_ptr
);
   default clocking dcb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   wire logic flt = o_rsp.general_protection_fault || o_rsp.stack_fault;
   wire logic l64 = i_req.valid && i_req.mode == agc_pkg::AGC_MODE_LONG64;
   a_rsp_one_cycle: assert property (o_rsp.valid == $past(i_req.valid))
      else $error("response valid not one cycle after request");
   a_canon_fault: assert property (
      l64 |=> flt == !(&o_rsp.lin_addr[63:47] || ~|o_rsp.lin_addr[63:47]))
      else $error("fault does not match canonical form");
   a_fault_long_only: assert property (flt |-> $past(l64))
      else $error("fault outside 64-bit access");
   a_faults_exclusive: assert property (
      !(o_rsp.general_protection_fault && o_rsp.stack_fault))
      else $error("both faults raised");
   a_flat_base: assert property (
      l64 && i_req.seg <= agc_pkg::AGC_SEG_STACK |=> o_rsp.lin_addr == o_rsp.eff_addr)
      else $error("legacy segment base applied in 64-bit mode");
   a_real_limit: assert property (
      i_req.valid && i_req.mode == agc_pkg::AGC_MODE_REAL
      |=> o_rsp.lin_addr <= agc_pkg::AGC_REAL_LIMIT)
      else $error("real mode linear address above limit");
   a_ip_narrow: assert property (
      i_ip_wr_size == agc_pkg::AGC_IPW_16 |=>
      o_wide_instr_ptr == {$past(o_wide_instr_ptr[63:16]), $past(i_ip_wr_val[15:0])})
      else $error("narrow pointer update wrong");
   a_ip_mid: assert property (
      i_ip_wr_size == agc_pkg::AGC_IPW_32 |=>
      o_wide_instr_ptr == {32'h0, $past(i_ip_wr_val[31:0])})
      else $error("mid pointer update not zero extended");
endmodule
bind agc_address_gen agc_address_gen_props i_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_req(i_req), .i_ip_wr_size(i_ip_wr_size), .i_ip_wr_val(i_ip_wr_val), .o_rsp(o_rsp),
   .o_wide_instr_ptr(o_wide_instr_ptr));

// ### verif/agc_pipe_model.sv
// Load/store pipeline sink counting responses
`timescale 1ns/1ps
module agc_pipe_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Responses
   input wire agc_pkg::agc_rsp_type i_rsp,
   output int o_taken
);
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_taken <= 0;
      end else if (i_rsp.valid === 1'b1) begin
         o_taken <= o_taken + 1;
      end
   end
endmodule

// ### verif/agc_address_gen_tb_top.sv
// Testbench for address generation
`timescale 1ns/1ps
module agc_address_gen_tb_top;
   localparam agc_pkg::agc_mode_type L64 = agc_pkg::AGC_MODE_LONG64;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   agc_pkg::agc_req_type req = '0;
   agc_pkg::agc_ipw_type ipsz = agc_pkg::AGC_IPW_NONE;
   logic [63:0] ipv = 64'h0;
   logic [63:0] tsb = 64'h0;
   agc_pkg::agc_rsp_type rsp;
   logic [63:0] ptr;
   int taken;
   int mismatches = 0;
   int samples_checked = 0;
   int sends = 0;
   agc_pkg::agc_req_type r;
   agc_address_gen i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req),
      .i_code_seg_base(64'h0000_0000_0000_0300), .i_data_seg_base(64'h0000_0000_0000_1000),
      .i_extra_seg_base(64'h0000_0000_0000_0500), .i_stack_seg_base(64'h0000_0000_0000_0700),
      .i_thread_seg_one_base(64'h0000_0000_0020_0000), .i_thread_seg_two_base(tsb),
      .i_ip_wr_size(ipsz), .i_ip_wr_val(ipv), .o_rsp(rsp), .o_wide_instr_ptr(ptr));
   agc_pipe_model i_pipe (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rsp(rsp), .o_taken(taken));
   initial begin
      forever #20 i_clk = ~i_clk;
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_flag(input logic g, input logic e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   function automatic agc_pkg::agc_req_type mk(agc_pkg::agc_mode_type m,
      agc_pkg::agc_seg_type s, logic [63:0] b);
      agc_pkg::agc_req_type q;
      q = '0;
      q.valid = 1'b1;
      q.mode = m;
      q.seg = s;
      q.base_valid = 1'b1;
      q.base_val = b;
      return q;
   endfunction
   task automatic send(input agc_pkg::agc_req_type q);
      @(posedge i_clk);
      req <= q;
      @(posedge i_clk);
      req <= '0;
      sends++;
      #1;
   endtask
   task automatic t_long;
      r = mk(L64, agc_pkg::AGC_SEG_DATA, 64'h0000_1000_0000_0000);
      r.index_valid = 1'b1;
      r.index_val = 64'h2;
      r.scale = 2'h3;
      r.disp = 64'hABCD_0000_FFFF_FFF0;
      send(r);
      chk(rsp.eff_addr, 64'h0000_1000_0000_0000);
      chk(rsp.lin_addr, 64'h0000_1000_0000_0000);
      r.base_valid = 1'b0;
      r.index_valid = 1'b0;
      r.wide_disp = 1'b1;
      r.disp = 64'h0000_7000_0000_1234;
      send(r);
      chk(rsp.eff_addr, 64'h0000_7000_0000_1234);
      r = mk(L64, agc_pkg::AGC_SEG_THREAD_ONE, 64'h0000_0001_FFFF_FFF0);
      r.disp = 64'h20;
      r.asz_override = 1'b1;
      r.seg_override = 1'b1;
      send(r);
      chk(rsp.eff_addr, 64'h10);
      chk(rsp.lin_addr, 64'h0000_0000_0020_0010);
      @(posedge i_clk);
      tsb <= 64'h0000_0100_0000_0000;
      r = mk(L64, agc_pkg::AGC_SEG_THREAD_TWO, 64'h0000_0000_FFFF_FFF0);
      r.disp = 64'h20;
      r.asz_override = 1'b1;
      send(r);
      chk(rsp.lin_addr, 64'h0000_0100_0000_0010);
   endtask
   task automatic t_canon;
      agc_pkg::agc_seg_type sg [6];
      sg = '{agc_pkg::AGC_SEG_DATA, agc_pkg::AGC_SEG_STACK, agc_pkg::AGC_SEG_THREAD_TWO,
         agc_pkg::AGC_SEG_STACK, agc_pkg::AGC_SEG_STACK, agc_pkg::AGC_SEG_DATA};
      for (int i = 0; i < 6; i++) begin
         r = mk(L64, sg[i], 64'h0000_8000_0000_0000);
         r.seg_override = (i > 1);
         r.base_is_stack_ptr = (i == 1 || i == 2);
         r.base_is_frame_ptr = (i == 4);
         r.implied_stack = (i == 5);
         send(r);
         chk_flag(rsp.stack_fault, (i == 1 || i > 3));
         chk_flag(rsp.general_protection_fault, !(i == 1 || i > 3));
      end
      r = mk(L64, agc_pkg::AGC_SEG_DATA, 64'hFFFF_8000_0000_0000);
      r.implied_stack = 1'b1;
      send(r);
      chk_flag(rsp.stack_fault, 1'b0);
      chk_flag(rsp.general_protection_fault, 1'b0);
   endtask
   task automatic t_legacy;
      r = mk(agc_pkg::AGC_MODE_REAL, agc_pkg::AGC_SEG_DATA, 64'h1234_5678);
      r.selector = 16'hABCD;
      send(r);
      chk(rsp.offset, 64'h5678);
      chk(rsp.lin_addr, 64'h6678);
      r.asz_override = 1'b1;
      send(r);
      chk(rsp.lin_addr, 64'h4_6678);
      r = mk(agc_pkg::AGC_MODE_PROT, agc_pkg::AGC_SEG_DATA, 64'h1_2345);
      r.selector = 16'hABCD;
      send(r);
      chk(rsp.offset, 64'h2345);
      chk({48'h0, rsp.selector}, 64'h0000_0000_0000_ABCD);
      r.seg_default_32 = 1'b1;
      send(r);
      chk(rsp.offset, 64'h1_2345);
      r.asz_override = 1'b1;
      send(r);
      chk(rsp.offset, 64'h2345);
      r.mode = agc_pkg::AGC_MODE_MGMT;
      send(r);
      chk_flag(rsp.mgmt_space, 1'b1);
      r = mk(agc_pkg::AGC_MODE_COMPAT, agc_pkg::AGC_SEG_DATA, 64'hFFFF_FFFF_0000_0010);
      r.seg_default_32 = 1'b1;
      send(r);
      chk(rsp.eff_addr, 64'h0000_0000_0000_0010);
      chk(rsp.lin_addr, 64'h0000_0000_0000_1010);
      chk_flag(rsp.general_protection_fault, 1'b0);
   endtask
   task automatic ipw(input agc_pkg::agc_ipw_type s, input logic [63:0] v, input logic [63:0] e);
      @(posedge i_clk);
      ipsz <= s;
      ipv <= v;
      @(posedge i_clk);
      ipsz <= agc_pkg::AGC_IPW_NONE;
      #1;
      chk(ptr, e);
   endtask
   task automatic conclude;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      #1;
      chk(rsp.lin_addr, 64'h0);
      chk(rsp.eff_addr, 64'h0);
      chk_flag(rsp.valid, 1'b0);
      chk_flag(rsp.general_protection_fault | rsp.stack_fault, 1'b0);
      chk(ptr, 64'h0);
      t_long;
      t_canon;
      t_legacy;
      ipw(agc_pkg::AGC_IPW_64, 64'h1111_2222_3333_4444, 64'h1111_2222_3333_4444);
      ipw(agc_pkg::AGC_IPW_16, 64'hFFFF_FFFF_FFFF_ABCD, 64'h1111_2222_3333_ABCD);
      ipw(agc_pkg::AGC_IPW_32, 64'hFFFF_FFFF_5555_6666, 64'h0000_0000_5555_6666);
      chk(64'(taken), 64'(sends));
      conclude;
   end
   initial begin
      repeat (2000) @(posedge i_clk);
      mismatches++;
      conclude;
   end
endmodule
